// ---- aimux_pkg.sv ----
// Package with constants for the converter input selection control block.
package aimux_pkg;

    // AXI4-Lite register byte offsets.
    localparam logic [7:0] AIMUX_OFF_SETUP  = 8'h00;
    localparam logic [7:0] AIMUX_OFF_SCAN   = 8'h04;
    localparam logic [7:0] AIMUX_OFF_STATUS = 8'h08;

    // Field positions in the first_setup_register.
    localparam int AIMUX_SEL_LSB  = 0;
    localparam int AIMUX_BO_LSB   = 8;
    localparam int AIMUX_MODE_BIT = 12;

    // Field positions in the status register.
    localparam int AIMUX_ST_BO_LSB   = 8;
    localparam int AIMUX_ST_SRC_BIT  = 10;
    localparam int AIMUX_ST_DIAG_BIT = 11;

    // Reset values.
    localparam logic [7:0] AIMUX_SEL_RST = 8'h00;
    localparam logic [1:0] AIMUX_BO_RST  = 2'h0;

    // Selector codes of one nibble.
    localparam logic [3:0] AIMUX_CODE_PIN0   = 4'h0;
    localparam logic [3:0] AIMUX_CODE_PIN1   = 4'h1;
    localparam logic [3:0] AIMUX_CODE_AGND   = 4'h8;
    localparam logic [3:0] AIMUX_CODE_AVDD   = 4'h9;
    localparam logic [3:0] AIMUX_CODE_REFPOS = 4'hB;
    localparam logic [3:0] AIMUX_CODE_REFNEG = 4'hC;
    localparam logic [3:0] AIMUX_CODE_DIODEH = 4'hD;
    localparam logic [3:0] AIMUX_CODE_DIODEL = 4'hE;
    localparam logic [3:0] AIMUX_CODE_BIAS   = 4'hF;

    // Whole select value that picks the temperature diodes.
    localparam logic [7:0] AIMUX_SEL_TEMP = 8'hDE;

    // Burnout current codes: off, 0.9 uA, 3.7 uA, 15 uA.
    localparam logic [1:0] AIMUX_BO_OFF  = 2'h0;
    localparam logic [1:0] AIMUX_BO_LOW  = 2'h1;
    localparam logic [1:0] AIMUX_BO_MID  = 2'h2;
    localparam logic [1:0] AIMUX_BO_HIGH = 2'h3;

    // AXI response codes.
    localparam logic [1:0] AIMUX_RESP_OKAY   = 2'h0;
    localparam logic [1:0] AIMUX_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        AIMUX_WR_IDLE = 3'b001,
        AIMUX_WR_DO   = 3'b010,
        AIMUX_WR_RESP = 3'b100
    } aimux_wr_t;

endpackage

// ---- aimux_decode.sv ----
// One selector nibble decoded into a switch vector with at most one bit set.
`timescale 1ns/10ps
module aimux_decode
    import aimux_pkg::*;
(
    input  wire logic [3:0]  code,
    output logic      [15:0] switch_on,
    output logic             legal
);

    // Each legal code closes one switch; reserved codes close none.
    always_comb begin
        switch_on = 16'h0000;
        legal     = 1'b1;
        case (code)
            AIMUX_CODE_PIN0, AIMUX_CODE_PIN1, AIMUX_CODE_AGND,
            AIMUX_CODE_AVDD, AIMUX_CODE_REFPOS, AIMUX_CODE_REFNEG,
            AIMUX_CODE_DIODEH, AIMUX_CODE_DIODEL,
            AIMUX_CODE_BIAS: begin
                switch_on[code] = 1'b1;
            end
            default: begin
                legal = 1'b0;
            end
        endcase
    end

endmodule // aimux_decode

// ---- aimux_top.sv ----
// Input selection and burnout current control with an AXI4-Lite slave.
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
// What this block does
// - Upper nibble positive, lower nibble negative selection
// - Nibble codes decode; reserved codes are unused
// - Positive and negative selectors fully independent
// - Scan mode uses sequencer code, else field
// - Two-bit burnout field, writable any time
// - Source on positive input, sink on negative
// - Burnout ignores conversion state entirely
// - Select 0xDE means temperature measurement
// - Diodes gate burnout off, enable diode bias
module aimux_top
    import aimux_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    input  wire logic [7:0]  SCAN_CODE,
    output logic [15:0]      POS_SWITCH,
    output logic [15:0]      NEG_SWITCH,
    output logic [1:0]       BURNOUT_SOURCE,
    output logic [1:0]       BURNOUT_SINK,
    output logic             DIODE_BIAS_EN
);

    ////////////////////////////////////////////////////////////////////////
    logic       rst_s1_ff;
    logic       rst_s2_ff;
    logic       rst_n;

    // Reset is released through two flops so release is clock aligned.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    assign rst_n = rst_s2_ff;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  sel_ff;
    logic [1:0]  bo_ff;
    logic        scan_mode_ff;
    logic [7:0]  scan_ff;
    aimux_wr_t   wr_st_ff;
    logic        aw_got_ff;
    logic        w_got_ff;
    logic [7:0]  waddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        wr_bad;

    // Write channel: address and data are taken in either order.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            wr_st_ff  <= AIMUX_WR_IDLE;
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            waddr_ff  <= 8'h00;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
            AWREADY   <= 1'b0;
            WREADY    <= 1'b0;
            BVALID    <= 1'b0;
            BRESP     <= AIMUX_RESP_OKAY;
        end else begin
            case (wr_st_ff)
                AIMUX_WR_IDLE: begin
                    AWREADY <= !aw_got_ff && !(AWVALID && AWREADY);
                    WREADY  <= !w_got_ff && !(WVALID && WREADY);
                    if (AWVALID && AWREADY) begin
                        aw_got_ff <= 1'b1;
                        waddr_ff  <= AWADDR;
                    end
                    if (WVALID && WREADY) begin
                        w_got_ff <= 1'b1;
                        wdata_ff <= WDATA;
                        wstrb_ff <= WSTRB;
                    end
                    if ((aw_got_ff || (AWVALID && AWREADY)) &&
                        (w_got_ff || (WVALID && WREADY))) begin
                        wr_st_ff <= AIMUX_WR_DO;
                        AWREADY  <= 1'b0;
                        WREADY   <= 1'b0;
                    end
                end
                AIMUX_WR_DO: begin
                    BVALID   <= 1'b1;
                    BRESP    <= wr_bad ? AIMUX_RESP_SLVERR
                                          : AIMUX_RESP_OKAY;
                    wr_st_ff <= AIMUX_WR_RESP;
                end
                AIMUX_WR_RESP: begin
                    if (BREADY) begin
                        BVALID    <= 1'b0;
                        aw_got_ff <= 1'b0;
                        w_got_ff  <= 1'b0;
                        wr_st_ff  <= AIMUX_WR_IDLE;
                    end
                end
                default: begin
                    wr_st_ff <= AIMUX_WR_IDLE;
                end
            endcase
        end
    end

    assign wr_bad = (waddr_ff != AIMUX_OFF_SETUP) &&
                    (waddr_ff != AIMUX_OFF_STATUS);

    // Configuration fields; the burnout field is accepted in any state.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            sel_ff       <= AIMUX_SEL_RST;
            bo_ff        <= AIMUX_BO_RST;
            scan_mode_ff <= 1'b0;
        end else if (wr_st_ff == AIMUX_WR_DO &&
                     waddr_ff == AIMUX_OFF_SETUP) begin
            if (wstrb_ff[0]) begin
                sel_ff <= wdata_ff[AIMUX_SEL_LSB +: 8];
            end
            if (wstrb_ff[1]) begin
                bo_ff        <= wdata_ff[AIMUX_BO_LSB +: 2];
                scan_mode_ff <= wdata_ff[AIMUX_MODE_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  scan_s1_ff;
    logic [7:0]  act_sel;
    logic        temp_sel;
    logic [15:0] pos_dec;
    logic [15:0] neg_dec;
    logic        pos_ok;
    logic        neg_ok;

    // Sequencer code arrives from outside the clock domain.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            scan_s1_ff <= 8'h00;
            scan_ff    <= 8'h00;
        end else begin
            scan_s1_ff <= SCAN_CODE;
            scan_ff    <= scan_s1_ff;
        end
    end

    assign act_sel  = scan_mode_ff ? scan_ff : sel_ff;
    assign temp_sel = (act_sel == AIMUX_SEL_TEMP);

    aimux_decode u_pos (
        .code      (act_sel[7:4]),
        .switch_on (pos_dec),
        .legal     (pos_ok)
    );

    aimux_decode u_neg (
        .code      (act_sel[3:0]),
        .switch_on (neg_dec),
        .legal     (neg_ok)
    );

    // Switches and current sources are registered; no conversion input.
    // The burnout code never looks at conversion state.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            POS_SWITCH     <= 16'h0001;
            NEG_SWITCH     <= 16'h0001;
            BURNOUT_SOURCE <= AIMUX_BO_OFF;
            BURNOUT_SINK   <= AIMUX_BO_OFF;
            DIODE_BIAS_EN  <= 1'b0;
        end else begin
            POS_SWITCH     <= pos_dec;
            NEG_SWITCH     <= neg_dec;
            BURNOUT_SOURCE <= temp_sel ? AIMUX_BO_OFF : bo_ff;
            BURNOUT_SINK   <= temp_sel ? AIMUX_BO_OFF : bo_ff;
            DIODE_BIAS_EN  <= temp_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel: one cycle to answer, held until taken.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= AIMUX_RESP_OKAY;
        end else begin
            ARREADY <= !RVALID && !(ARVALID && ARREADY);
            if (ARVALID && ARREADY) begin
                RVALID <= 1'b1;
                RRESP  <= AIMUX_RESP_OKAY;
                RDATA  <= 32'h0000_0000;
                case (ARADDR)
                    AIMUX_OFF_SETUP: begin
                        RDATA[AIMUX_SEL_LSB +: 8]  <= sel_ff;
                        RDATA[AIMUX_BO_LSB +: 2]   <= bo_ff;
                        RDATA[AIMUX_MODE_BIT]      <= scan_mode_ff;
                    end
                    AIMUX_OFF_STATUS: begin
                        RDATA[AIMUX_SEL_LSB +: 8]     <= act_sel;
                        RDATA[AIMUX_ST_BO_LSB +: 2]   <= BURNOUT_SOURCE;
                        RDATA[AIMUX_ST_SRC_BIT]       <= DIODE_BIAS_EN;
                        RDATA[AIMUX_ST_DIAG_BIT]      <= !(pos_ok && neg_ok);
                    end
                    default: begin
                        RRESP <= AIMUX_RESP_SLVERR;
                    end
                endcase
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_temp_now;
        act_sel == AIMUX_SEL_TEMP;
    endsequence

    sequence s_no_burnout;
        BURNOUT_SOURCE == AIMUX_BO_OFF && DIODE_BIAS_EN;
    endsequence

    AST_POS_UPPER: assert property (@(posedge CLK) disable iff (!rst_n)
        ##1 POS_SWITCH == (16'h0001 << $past(act_sel[7:4])) || !$past(pos_ok))
        else $error("Positive switch does not follow upper nibble.");

    AST_NEG_LOWER: assert property (@(posedge CLK) disable iff (!rst_n)
        $past(neg_ok) |-> NEG_SWITCH == (16'h0001 << $past(act_sel[3:0])))
        else $error("Negative switch does not follow lower nibble.");

    AST_RESERVED_OPEN: assert property (@(posedge CLK) disable iff (!rst_n)
        !pos_ok |=> POS_SWITCH == 16'h0000)
        else $error("Reserved code closed a switch.");

    AST_SCAN_SOURCE: assert property (@(posedge CLK) disable iff (!rst_n)
        scan_mode_ff |-> act_sel == scan_ff)
        else $error("Scan mode does not use sequencer code.");

    AST_BURNOUT_FOLLOWS: assert property (@(posedge CLK) disable iff (!rst_n)
        !temp_sel |=> BURNOUT_SOURCE == $past(bo_ff))
        else $error("Burnout source not equal to field.");

    AST_SINK_EQ_SOURCE: assert property (@(posedge CLK) disable iff (!rst_n)
        BURNOUT_SINK == BURNOUT_SOURCE)
        else $error("Sink and source differ.");

    AST_TEMP_GATES: assert property (@(posedge CLK) disable iff (!rst_n)
        s_temp_now |=> s_no_burnout)
        else $error("Burnout not gated for diode selection.");

    AST_FIELD_KEPT: assert property (@(posedge CLK) disable iff (!rst_n)
        (s_temp_now and (wr_st_ff != AIMUX_WR_DO)) |=> $stable(bo_ff))
        else $error("Burnout field changed by diode selection.");

    AST_BIAS_ONLY_TEMP: assert property (@(posedge CLK) disable iff (!rst_n)
        DIODE_BIAS_EN |-> $past(act_sel) == AIMUX_SEL_TEMP)
        else $error("Diode bias on without temperature select.");

endmodule // aimux_top

// ---- aimux_far.sv ----
// Behavioural model of the analog pins that the selection block drives.
`timescale 1ns/10ps
module aimux_far
(
    input  wire logic [15:0] pos_switch,
    input  wire logic [15:0] neg_switch,
    input  wire logic [1:0]  bo_source,
    input  wire logic [1:0]  bo_sink,
    input  wire logic        bias_en,
    output logic             wiring_ok
);
    // Each pin takes one source at most; the pins must agree on the current.
    always_comb begin
        wiring_ok = ($countones(pos_switch) <= 1)
                 && ($countones(neg_switch) <= 1)
                 && (bo_source === bo_sink)
                 && !(bias_en && bo_source != 2'h0);
    end
endmodule // aimux_far

// ---- aimux_tb.sv ----
// Self-checking testbench for the input selection block.
`timescale 1ns/10ps
`define CHK(g, e) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("BAD %0t got %h exp %h", $time, g, e); \
    end \
end
module aimux_tb
    import aimux_pkg::*;
;
    logic        CLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, DIODE_BIAS_EN;
    logic        wiring_ok;
    logic [7:0]  AWADDR, ARADDR, SCAN_CODE;
    logic [3:0]  WSTRB;
    logic [1:0]  BRESP, RRESP, BURNOUT_SOURCE, BURNOUT_SINK, resp;
    logic [31:0] WDATA, RDATA, rd;
    logic [15:0] POS_SWITCH, NEG_SWITCH;
    int          mismatches, cmp_count, cyc;
    typedef struct packed {
        logic [7:0]  sel;
        logic [1:0]  bo;
        logic        mode;
        logic [7:0]  scan;
        logic [15:0] pos, neg;
        logic [1:0]  ebo;
        logic        bias;
    } aimux_row_t;
    aimux_row_t r;
    aimux_row_t rows [11] = '{
        '{8'h01,2'h1,1'h0,8'h00,16'h0001,16'h0002,2'h1,1'h0},
        '{8'h10,2'h2,1'h0,8'h00,16'h0002,16'h0001,2'h2,1'h0},
        '{8'h89,2'h3,1'h0,8'h00,16'h0100,16'h0200,2'h3,1'h0},
        '{8'hBC,2'h0,1'h0,8'h00,16'h0800,16'h1000,2'h0,1'h0},
        '{8'hFD,2'h1,1'h0,8'h00,16'h8000,16'h2000,2'h1,1'h0},
        '{8'hEF,2'h2,1'h0,8'h00,16'h4000,16'h8000,2'h2,1'h0},
        '{8'h99,2'h3,1'h0,8'h00,16'h0200,16'h0200,2'h3,1'h0},
        '{8'hDE,2'h3,1'h0,8'h00,16'h2000,16'h4000,2'h0,1'h1},
        '{8'h3A,2'h1,1'h0,8'h00,16'h0000,16'h0000,2'h1,1'h0},
        '{8'h01,2'h2,1'h1,8'hDE,16'h2000,16'h4000,2'h0,1'h1},
        '{8'hDE,2'h1,1'h1,8'h8F,16'h0100,16'h8000,2'h1,1'h0}};

    aimux_top dut (.CLK(CLK), .RST_N(RST_N), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
        .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
        .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
        .RREADY(RREADY), .SCAN_CODE(SCAN_CODE), .POS_SWITCH(POS_SWITCH),
        .NEG_SWITCH(NEG_SWITCH), .BURNOUT_SOURCE(BURNOUT_SOURCE),
        .BURNOUT_SINK(BURNOUT_SINK), .DIODE_BIAS_EN(DIODE_BIAS_EN));
    aimux_far far (.pos_switch(POS_SWITCH), .neg_switch(NEG_SWITCH),
        .bo_source(BURNOUT_SOURCE), .bo_sink(BURNOUT_SINK),
        .bias_en(DIODE_BIAS_EN), .wiring_ok(wiring_ok));

    always #4 CLK = ~CLK;

    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // The tests need well under a thousand cycles; this cuts a hang short.
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic aw_open;
        logic w_open;
        @(posedge CLK);
        AWADDR  <= a;
        WDATA   <= d;
        AWVALID <= 1'h1;
        WVALID  <= 1'h1;
        BREADY  <= 1'h1;
        aw_open = 1'b1;
        w_open  = 1'b1;
        while (aw_open || w_open) begin
            @(posedge CLK);
            if (aw_open && AWREADY === 1'h1) begin
                AWVALID <= 1'h0;
                aw_open = 1'b0;
            end
            if (w_open && WREADY === 1'h1) begin
                WVALID <= 1'h0;
                w_open = 1'b0;
            end
        end
        do @(posedge CLK); while (BVALID !== 1'h1);
        resp = BRESP;
        BREADY <= 1'h0;
    endtask

    task automatic axr(input logic [7:0] a);
        @(posedge CLK);
        ARADDR  <= a;
        ARVALID <= 1'h1;
        RREADY  <= 1'h1;
        do @(posedge CLK); while (ARREADY !== 1'h1);
        ARVALID <= 1'h0;
        do @(posedge CLK); while (RVALID !== 1'h1);
        rd = RDATA;
        resp = RRESP;
        RREADY <= 1'h0;
    endtask

    task automatic chk_rst;
        `CHK(POS_SWITCH, 16'h0001)
        `CHK(NEG_SWITCH, 16'h0001)
        `CHK({BURNOUT_SOURCE, BURNOUT_SINK, DIODE_BIAS_EN}, 5'h00)
    endtask

    initial begin
        {CLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 7'h00;
        {AWADDR, ARADDR, SCAN_CODE, WDATA} = 56'h0;
        WSTRB = 4'hF;
        repeat (5) @(posedge CLK);
        RST_N <= 1'h1;
        repeat (4) @(posedge CLK);
        chk_rst();
        foreach (rows[i]) begin
            r = rows[i];
            SCAN_CODE <= r.scan;
            axw(AIMUX_OFF_SETUP, {19'h0, r.mode, 2'h0, r.bo, r.sel});
            `CHK(resp, AIMUX_RESP_OKAY)
            repeat (2) @(posedge CLK);
            `CHK(POS_SWITCH, r.pos)
            `CHK(NEG_SWITCH, r.neg)
            `CHK(BURNOUT_SOURCE, r.ebo)
            `CHK(BURNOUT_SINK, r.ebo)
            `CHK(DIODE_BIAS_EN, r.bias)
            `CHK(wiring_ok, 1'h1)
            axr(AIMUX_OFF_STATUS);
            `CHK(rd[10:0], {r.bias, r.ebo, r.mode ? r.scan : r.sel})
            `CHK(rd[11], (r.pos == 16'h0) || (r.neg == 16'h0))
        end
        // The current must keep flowing through a long idle stretch.
        repeat (100) @(posedge CLK);
        `CHK(BURNOUT_SOURCE, 2'h1)
        axr(AIMUX_OFF_SETUP);
        `CHK(rd, 32'h000011DE)
        axw(AIMUX_OFF_SCAN, 32'hFFFFFFFF);
        `CHK(resp, AIMUX_RESP_SLVERR)
        axr(AIMUX_OFF_SCAN);
        `CHK({resp, rd}, {AIMUX_RESP_SLVERR, 32'h0})
        axr(AIMUX_OFF_SETUP);
        `CHK(rd, 32'h000011DE)
        RST_N <= 1'h0;
        repeat (3) @(posedge CLK);
        chk_rst();
        RST_N <= 1'h1;
        repeat (5) @(posedge CLK);
        chk_rst();
        axr(AIMUX_OFF_SETUP);
        `CHK(rd, 32'h0)
        give_verdict();
    end
endmodule // aimux_tb
